// >>> core/rcp_pkg.sv
// How it works
// - Upper and lower case letters decode alike.
// - Space, comma and semicolon each end any partial command.
// - Parity bit of every character ignored.
// - Function commands: digit 0 disables, 1 enables.
// - Edit and both latches disabled after reset.
// - Start and stop act on rising edge after reset.
// - Clock polarity: 1 rising, 2 falling.
// - Start/stop polarity: 1 rising, 2 falling.
// - Qualifier polarity: 1 active high, 2 low.
// - No latch enabled means free-running measurements.
// - Latest result held, overwritten by next one.
// - Bus trigger or probe switch marks triggered measurement.
// - After a send request, resume continuous measuring.
// - Any command cancels a pending send request.
// - Error request answers two decimal digits, 00 clean.
// - Identification answers string plus CR LF.
// - Current probe request answers a two-letter code.
// - Summary waits trigger, records probe through gate.
// - Summary code: highs, lows, both, or neither.
// - Polarity byte sent in decimal with fixed weights.
// - Talker gets only the latest held signature, not a queue.
// - Triggered signature request waits for a trigger and the next completion, then sends that signature.
package rcp_pkg;
	// Character handling.
	localparam logic [6:0] CH_CASE   = 7'h20;
	localparam logic [6:0] CH_LOW_A  = 7'h61;
	localparam logic [6:0] CH_LOW_Z  = 7'h7A;
	localparam logic [6:0] CH_SPACE  = 7'h20;
	localparam logic [6:0] CH_COMMA  = 7'h2C;
	localparam logic [6:0] CH_SEMI   = 7'h3B;
	localparam logic [6:0] CH_0      = 7'h30;
	localparam logic [6:0] CH_1      = 7'h31;
	localparam logic [6:0] CH_2      = 7'h32;
	localparam logic [6:0] CH_C      = 7'h43;
	localparam logic [6:0] CH_E      = 7'h45;
	localparam logic [6:0] CH_F      = 7'h46;
	localparam logic [6:0] CH_I      = 7'h49;
	localparam logic [6:0] CH_L      = 7'h4C;
	localparam logic [6:0] CH_P      = 7'h50;
	localparam logic [6:0] CH_Q      = 7'h51;
	localparam logic [6:0] CH_R      = 7'h52;
	localparam logic [6:0] CH_S      = 7'h53;
	localparam logic [6:0] CH_T      = 7'h54;
	localparam logic [6:0] CH_U      = 7'h55;
	localparam logic [7:0] ASC_0     = 8'h30;
	localparam logic [7:0] ASC_A     = 8'h41;
	localparam logic [7:0] ASC_CR    = 8'h0D;
	localparam logic [7:0] ASC_LF    = 8'h0A;
	// Two-letter probe answers.
	localparam logic [15:0] RPT_HIGH  = 16'h4849;
	localparam logic [15:0] RPT_LOW   = 16'h4C4F;
	localparam logic [15:0] RPT_PULSE = 16'h5055;
	localparam logic [15:0] RPT_FLOAT = 16'h464C;
	// Probe indication codes from the probe front end.
	localparam logic [1:0] PRB_HIGH  = 2'h0;
	localparam logic [1:0] PRB_LOW   = 2'h1;
	localparam logic [1:0] PRB_PULSE = 2'h2;
	localparam logic [1:0] PRB_FLOAT = 2'h3;
	// Polarity byte bit positions.
	localparam int POL_CLK  = 0;
	localparam int POL_STA  = 1;
	localparam int POL_STO  = 2;
	localparam int POL_QEN  = 4;
	localparam int POL_QLEV = 5;
	// Identification text; the value is arbitrary.
	localparam logic [3:0]  ID_LEN  = 4'h7;
	localparam logic [55:0] ID_TEXT = 56'h53494741_4E3031;
	// Answer lengths and misc.
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [3:0] LEN_TWO = 4'h2;
	localparam logic [3:0] LEN_SIG = 4'h4;
	localparam logic [6:0] DEC_TEN = 7'h0A;
	typedef enum logic [3:0] {
		C_NONE, C_RECALL, C_EDIT, C_SIGL, C_UNSL, C_QUAL, C_PCLK, C_PSTA, C_PSTO,
		C_PQUAL, C_ERR, C_ID, C_PROBE, C_SUMMARY, C_POL, C_TRIGSIG
	} rcp_cmd_t;
	typedef enum logic [2:0] {MD_NORMAL, MD_SS_TRIG, MD_SS_SIG, MD_SL_TRIG, MD_SL_ARM, MD_SL_GATE} rcp_mode_t;
	typedef enum logic [1:0] {PS_FIRST, PS_SECOND, PS_ARG} rcp_pstate_t;
	typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_LOAD, TX_SEND} rcp_tx_t;
endpackage

// >>> core/rcp_id_rom.sv
`timescale 1ns/1ps
module rcp_id_rom import rcp_pkg::*; (
	// Clocking.
	input  wire logic       clk_in,
	input  wire logic       ce_in,
	input  wire logic       sys_rst_in,
	// Read port.
	input  wire logic [3:0] addr_in,
	output logic      [7:0] data_out
);
	logic [7:0] tbl [16];

	// One entry per character of the identification text, first character at address zero.
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_tbl
			if (gi < ID_LEN) begin : g_used
				assign tbl[gi] = ID_TEXT[8*(ID_LEN-1-gi) +: 8];
			end else begin : g_free
				assign tbl[gi] = 8'h00;
			end
		end
	endgenerate

	// Registered read, one cycle behind the address.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			data_out <= 8'h00;
		end else if (ce_in) begin
			data_out <= tbl[addr_in];
		end
	end
endmodule

// >>> core/rcp_parser.sv
`timescale 1ns/1ps
module rcp_parser import rcp_pkg::*; (
	// Clock, enable and reset.
	input  wire logic        clk_in,
	input  wire logic        ce_in,
	input  wire logic        sys_rst_in,
	// Command characters from the bus listener.
	input  wire logic [7:0]  cmd_data_in,
	input  wire logic        cmd_valid_in,
	output logic             cmd_ready_out,
	// Trigger sources.
	input  wire logic        bus_trigger_in,
	input  wire logic        probe_switch_in,
	// Measurement engine and probe.
	input  wire logic        meas_done_in,
	input  wire logic [15:0] sig_data_in,
	input  wire logic        gate_active_in,
	input  wire logic        probe_high_in,
	input  wire logic        probe_low_in,
	input  wire logic [1:0]  probe_state_in,
	input  wire logic [6:0]  error_code_in,
	// Answer characters to the bus talker.
	input  wire logic        talker_in,
	output logic [7:0]       tx_data_out,
	output logic             tx_valid_out,
	input  wire logic        tx_ready_in,
	// Settings and status.
	output logic             recall_en_out,
	output logic             edit_en_out,
	output logic             sig_latch_en_out,
	output logic             unstable_latch_en_out,
	output logic             qualify_en_out,
	output logic             clock_rising_out,
	output logic             start_rising_out,
	output logic             stop_rising_out,
	output logic             qual_high_out,
	output logic             free_run_out,
	output logic             triggered_meas_out,
	output logic [15:0]      held_sig_out,
	output logic             send_pending_out
);
	rcp_pstate_t ps_r;
	rcp_mode_t   mode_r;
	rcp_tx_t     tx_r;
	rcp_cmd_t    pair_cmd;
	rcp_cmd_t    exec_cmd;
	logic [6:0]  ch;
	logic [6:0]  c1_r;
	logic [6:0]  c2_r;
	logic        cmd_fire;
	logic        is_sep;
	logic        trig;
	logic        start_cmd;
	logic        start_sum;
	logic        start_sig;
	logic        tx_accept;
	logic        seen_hi_r;
	logic        seen_lo_r;
	logic        sig_pend_r;
	logic        rom_sel_r;
	logic [3:0]  len_r;
	logic [3:0]  idx_r;
	logic [31:0] resp_r;
	logic [7:0]  rom_q;
	logic [7:0]  pol_byte;
	logic [6:0]  pol_val;

	// Hex digit to ASCII for signature answers.
	function automatic logic [7:0] hex_asc(input logic [3:0] n);
		hex_asc = (n < 4'hA) ? ASC_0 + {4'h0, n} : ASC_A + {4'h0, n} - 8'h0A;
	endfunction

	// Two ASCII decimal digits of a value below one hundred.
	function automatic logic [15:0] dec2(input logic [6:0] v);
		logic [6:0] t;
		logic [6:0] o;
		t = v / DEC_TEN;
		o = v % DEC_TEN;
		dec2 = {ASC_0 + {1'b0, t}, ASC_0 + {1'b0, o}};
	endfunction

	// Which command a letter pair names; argument is checked later.
	function automatic rcp_cmd_t classify(input logic [6:0] a, input logic [6:0] b);
		classify = C_NONE;
		if (a == CH_F) begin
			if (b == CH_R) classify = C_RECALL;
			else if (b == CH_E) classify = C_EDIT;
			else if (b == CH_S) classify = C_SIGL;
			else if (b == CH_U) classify = C_UNSL;
			else if (b == CH_Q) classify = C_QUAL;
		end else if (a == CH_P) begin
			if (b == CH_C) classify = C_PCLK;
			else if (b == CH_T) classify = C_PSTA;
			else if (b == CH_P) classify = C_PSTO;
			else if (b == CH_Q) classify = C_PQUAL;
		end else if (a == CH_S) begin
			if (b == CH_E) classify = C_ERR;
			else if (b == CH_I) classify = C_ID;
			else if (b == CH_P) classify = C_POL;
			else if (b == CH_L) classify = C_PROBE;
			else if (b == CH_S) classify = C_TRIGSIG;
		end
	endfunction

	function automatic logic no_arg(input rcp_cmd_t c);
		no_arg = (c == C_ERR) || (c == C_ID) || (c == C_POL);
	endfunction

	// Drop the parity bit and fold lower case onto upper case.
	always_comb begin
		ch = cmd_data_in[6:0];
		if (ch >= CH_LOW_A && ch <= CH_LOW_Z) begin
			ch = ch & ~CH_CASE;
		end
	end

	assign is_sep = (ch == CH_SPACE) || (ch == CH_COMMA) || (ch == CH_SEMI);
	assign cmd_ready_out = (tx_r == TX_IDLE);
	assign cmd_fire = cmd_valid_in && cmd_ready_out;
	assign trig = bus_trigger_in || probe_switch_in;

	// Decide which command, if any, completes with this character.
	always_comb begin
		pair_cmd = classify(c1_r, ps_r == PS_SECOND ? ch : c2_r);
		exec_cmd = C_NONE;
		if (cmd_fire && !is_sep) begin
			if (ps_r == PS_SECOND && no_arg(pair_cmd)) begin
				exec_cmd = pair_cmd;
			end else if (ps_r == PS_ARG) begin
				if (pair_cmd == C_PROBE) begin
					exec_cmd = (ch == CH_1) ? C_PROBE : (ch == CH_2) ? C_SUMMARY : C_NONE;
				end else if (pair_cmd == C_TRIGSIG) begin
					exec_cmd = (ch == CH_1) ? C_TRIGSIG : C_NONE;
				end else begin
					exec_cmd = pair_cmd;
				end
			end
		end
	end

	// Character sequencer; separators abandon any partial command.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ps_r <= PS_FIRST;
			c1_r <= 7'h00;
			c2_r <= 7'h00;
		end else if (ce_in && cmd_fire) begin
			if (is_sep) begin
				ps_r <= PS_FIRST;
			end else begin
				unique case (ps_r)
					PS_FIRST: begin
						c1_r <= ch;
						ps_r <= PS_SECOND;
					end
					PS_SECOND: begin
						c2_r <= ch;
						ps_r <= (pair_cmd != C_NONE && !no_arg(pair_cmd)) ? PS_ARG : PS_FIRST;
					end
					PS_ARG: ps_r <= PS_FIRST;
				endcase
			end
		end
	end

	// Function enables, cleared by reset.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			recall_en_out         <= 1'b0;
			edit_en_out           <= 1'b0;
			sig_latch_en_out      <= 1'b0;
			unstable_latch_en_out <= 1'b0;
			qualify_en_out        <= 1'b0;
		end else if (ce_in && (ch == CH_0 || ch == CH_1)) begin
			// Digit 0 disables, digit 1 enables.
			unique case (exec_cmd)
				C_RECALL: recall_en_out         <= (ch == CH_1);
				C_EDIT:   edit_en_out           <= (ch == CH_1);
				C_SIGL:   sig_latch_en_out      <= (ch == CH_1);
				C_UNSL:   unstable_latch_en_out <= (ch == CH_1);
				C_QUAL:   qualify_en_out        <= (ch == CH_1);
				default: ;
			endcase
		end
	end

	// Edge and level polarities; 1 selects rising or high, 2 falling or low.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			clock_rising_out <= 1'b1;
			start_rising_out <= 1'b1;
			stop_rising_out  <= 1'b1;
			qual_high_out    <= 1'b1;
		end else if (ce_in && (ch == CH_1 || ch == CH_2)) begin
			unique case (exec_cmd)
				C_PCLK:  clock_rising_out <= (ch == CH_1);
				C_PSTA:  start_rising_out <= (ch == CH_1);
				C_PSTO:  stop_rising_out  <= (ch == CH_1);
				C_PQUAL: qual_high_out    <= (ch == CH_1);
				default: ;
			endcase
		end
	end

	// Free running whenever neither latch is on.
	assign free_run_out = !sig_latch_en_out && !unstable_latch_en_out;

	// Next measurement is a triggered one; a new trigger beats the clear.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			triggered_meas_out <= 1'b0;
		end else if (ce_in) begin
			if (trig) begin
				triggered_meas_out <= 1'b1;
			end else if (meas_done_in) begin
				triggered_meas_out <= 1'b0;
			end
		end
	end

	// Latest signature is held and replaced by the next completion.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			held_sig_out <= 16'h0000;
		end else if (ce_in && meas_done_in) begin
			held_sig_out <= sig_data_in;
		end
	end

	// Send-data request tracking.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mode_r <= MD_NORMAL;
		end else if (ce_in) begin
			if (exec_cmd != C_NONE) begin
				// Any command drops a waiting request.
				mode_r <= (exec_cmd == C_TRIGSIG) ? MD_SS_TRIG : (exec_cmd == C_SUMMARY) ? MD_SL_TRIG : MD_NORMAL;
			end else begin
				unique case (mode_r)
					MD_NORMAL:  ;
					MD_SS_TRIG: if (trig) mode_r <= MD_SS_SIG;
					MD_SS_SIG:  if (start_sig) mode_r <= MD_NORMAL;
					MD_SL_TRIG: if (trig) mode_r <= MD_SL_ARM;
					MD_SL_ARM:  if (gate_active_in) mode_r <= MD_SL_GATE;
					MD_SL_GATE: if (start_sum) mode_r <= MD_NORMAL;
				endcase
			end
		end
	end

	assign send_pending_out = (mode_r != MD_NORMAL);

	// Probe levels seen during the triggered gate.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			seen_hi_r <= 1'b0;
			seen_lo_r <= 1'b0;
		end else if (ce_in) begin
			if (mode_r == MD_SL_TRIG) begin
				seen_hi_r <= 1'b0;
				seen_lo_r <= 1'b0;
			end else if ((mode_r == MD_SL_ARM || mode_r == MD_SL_GATE) && gate_active_in) begin
				seen_hi_r <= seen_hi_r || probe_high_in;
				seen_lo_r <= seen_lo_r || probe_low_in;
			end
		end
	end

	// Signature waiting for the talker; a new completion wins over the clear.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sig_pend_r <= 1'b0;
		end else if (ce_in) begin
			if (meas_done_in && (mode_r == MD_NORMAL || mode_r == MD_SS_SIG)) begin
				sig_pend_r <= 1'b1;
			end else if (start_sig || exec_cmd == C_TRIGSIG || exec_cmd == C_SUMMARY) begin
				sig_pend_r <= 1'b0;
			end
		end
	end

	// Who starts the answer engine; command answers come first.
	assign start_cmd = (exec_cmd == C_ERR) || (exec_cmd == C_ID) || (exec_cmd == C_PROBE) || (exec_cmd == C_POL);
	assign start_sum = (tx_r == TX_IDLE) && !start_cmd && mode_r == MD_SL_GATE && !gate_active_in;
	assign start_sig = (tx_r == TX_IDLE) && !start_cmd && !start_sum && sig_pend_r && talker_in &&
		(mode_r == MD_NORMAL || mode_r == MD_SS_SIG);

	// Polarity byte; unused weights stay zero.
	always_comb begin
		pol_byte = 8'h00;
		pol_byte[POL_CLK]  = clock_rising_out;
		pol_byte[POL_STA]  = start_rising_out;
		pol_byte[POL_STO]  = stop_rising_out;
		pol_byte[POL_QEN]  = qualify_en_out;
		pol_byte[POL_QLEV] = qual_high_out;
		pol_val = pol_byte[6:0];
	end

	// Answer body: loaded at start, shifted one byte per sent body byte.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			resp_r    <= 32'h0000_0000;
			len_r     <= 4'h0;
			rom_sel_r <= 1'b0;
		end else if (ce_in) begin
			if (start_cmd) begin
				rom_sel_r <= (exec_cmd == C_ID);
				unique case (exec_cmd)
					C_ERR: begin
						resp_r <= {dec2(error_code_in), 16'h0000};
						len_r  <= LEN_TWO;
					end
					C_ID: len_r <= ID_LEN;
					C_PROBE: begin
						unique case (probe_state_in)
							PRB_HIGH:  resp_r <= {RPT_HIGH, 16'h0000};
							PRB_LOW:   resp_r <= {RPT_LOW, 16'h0000};
							PRB_PULSE: resp_r <= {RPT_PULSE, 16'h0000};
							PRB_FLOAT: resp_r <= {RPT_FLOAT, 16'h0000};
						endcase
						len_r <= LEN_TWO;
					end
					default: begin
						// Decimal without a leading zero.
						if (pol_val < DEC_TEN) begin
							resp_r <= {dec2(pol_val), 16'h0000} << 8;
							len_r  <= LEN_ONE;
						end else begin
							resp_r <= {dec2(pol_val), 16'h0000};
							len_r  <= LEN_TWO;
						end
					end
				endcase
			end else if (start_sum) begin
				rom_sel_r <= 1'b0;
				len_r     <= LEN_TWO;
				if (seen_hi_r && seen_lo_r) resp_r <= {RPT_PULSE, 16'h0000};
				else if (seen_hi_r) resp_r <= {RPT_HIGH, 16'h0000};
				else if (seen_lo_r) resp_r <= {RPT_LOW, 16'h0000};
				else resp_r <= {RPT_FLOAT, 16'h0000};
			end else if (start_sig) begin
				rom_sel_r <= 1'b0;
				len_r     <= LEN_SIG;
				resp_r    <= {hex_asc(held_sig_out[15:12]), hex_asc(held_sig_out[11:8]),
					hex_asc(held_sig_out[7:4]), hex_asc(held_sig_out[3:0])};
			end else if (tx_accept && idx_r < len_r) begin
				resp_r <= resp_r << 8;
			end
		end
	end

	assign tx_accept = (tx_r == TX_SEND) && tx_ready_in;
	assign tx_valid_out = (tx_r == TX_SEND);

	// Answer engine: body bytes, then CR and LF.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_r        <= TX_IDLE;
			idx_r       <= 4'h0;
			tx_data_out <= 8'h00;
		end else if (ce_in) begin
			unique case (tx_r)
				TX_IDLE: begin
					if (start_cmd || start_sum || start_sig) begin
						idx_r <= 4'h0;
						tx_r  <= TX_FETCH;
					end
				end
				TX_FETCH: tx_r <= TX_LOAD;
				TX_LOAD: begin
					if (idx_r < len_r) begin
						tx_data_out <= rom_sel_r ? rom_q : resp_r[31:24];
					end else if (idx_r == len_r) begin
						tx_data_out <= ASC_CR;
					end else begin
						tx_data_out <= ASC_LF;
					end
					tx_r <= TX_SEND;
				end
				TX_SEND: begin
					if (tx_ready_in) begin
						if (idx_r == len_r + 4'h1) begin
							tx_r <= TX_IDLE;
						end else begin
							idx_r <= idx_r + 4'h1;
							tx_r  <= TX_FETCH;
						end
					end
				end
			endcase
		end
	end

	// Identification text store.
	rcp_id_rom u_id_rom (
		.clk_in     (clk_in),
		.ce_in      (ce_in),
		.sys_rst_in (sys_rst_in),
		.addr_in    (idx_r),
		.data_out   (rom_q)
	);
endmodule

// >>> tb/rcp_parser_props.sv
`timescale 1ns/1ps
module rcp_parser_props import rcp_pkg::*; (
	// Clock and reset.
	input wire logic        clk_in,
	input wire logic        ce_in,
	input wire logic        sys_rst_in,
	// Watched ports.
	input wire logic        cmd_ready_out,
	input wire logic        bus_trigger_in,
	input wire logic        probe_switch_in,
	input wire logic        meas_done_in,
	input wire logic [15:0] sig_data_in,
	input wire logic [7:0]  tx_data_out,
	input wire logic        tx_valid_out,
	input wire logic        tx_ready_in,
	input wire logic        edit_en_out,
	input wire logic        sig_latch_en_out,
	input wire logic        unstable_latch_en_out,
	input wire logic        start_rising_out,
	input wire logic        stop_rising_out,
	input wire logic        free_run_out,
	input wire logic        triggered_meas_out,
	input wire logic [15:0] held_sig_out
);
	// All checks share the one clock and its reset.
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// The engine starts, then the first byte shows two cycles later.
	sequence s_start;
		$fell(cmd_ready_out) && !tx_valid_out;
	endsequence
	sequence s_first;
		!tx_valid_out ##1 tx_valid_out;
	endsequence
	a_answer_latency: assert property (s_start |-> ##1 s_first)
		else $error("first answer byte late or early");
	a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
		else $error("answer byte dropped before acceptance");
	a_free_run: assert property (free_run_out == !(sig_latch_en_out || unstable_latch_en_out))
		else $error("free run flag wrong");
	a_held_load: assert property (ce_in && meas_done_in |=> held_sig_out == $past(sig_data_in))
		else $error("result not held");
	a_held_keep: assert property (!meas_done_in |=> $stable(held_sig_out))
		else $error("held result changed without completion");
	a_trig_mark: assert property (ce_in && (bus_trigger_in || probe_switch_in) |=> triggered_meas_out)
		else $error("trigger not marked");
	a_trig_done: assert property (ce_in && meas_done_in && !bus_trigger_in && !probe_switch_in
		|=> !triggered_meas_out)
		else $error("triggered mark not cleared");
	a_reset_vals: assert property ($fell(sys_rst_in) |-> !edit_en_out && !sig_latch_en_out
		&& !unstable_latch_en_out && start_rising_out && stop_rising_out)
		else $error("reset defaults wrong");
endmodule

bind rcp_parser rcp_parser_props u_props (
	.clk_in, .ce_in, .sys_rst_in, .cmd_ready_out, .bus_trigger_in, .probe_switch_in, .meas_done_in,
	.sig_data_in, .tx_data_out, .tx_valid_out, .tx_ready_in, .edit_en_out, .sig_latch_en_out,
	.unstable_latch_en_out, .start_rising_out, .stop_rising_out, .free_run_out, .triggered_meas_out,
	.held_sig_out
);

// >>> tb/rcp_bus_ctrl.sv
`timescale 1ns/1ps
module rcp_bus_ctrl import rcp_pkg::*; (
	// Clock.
	input  wire logic       clk_in,
	// Command side.
	input  wire logic       cmd_ready_in,
	output logic      [7:0] cmd_data_out,
	output logic            cmd_valid_out,
	// Answer side.
	input  wire logic [7:0] tx_data_in,
	input  wire logic       tx_valid_in,
	output logic            tx_ready_out
);
	int stall = 0;
	// Lines start quiet.
	initial begin
		cmd_data_out = 8'h00;
		cmd_valid_out = 1'b0;
		tx_ready_out = 1'b0;
	end
	// Offers one character and holds it until taken or 200 cycles pass; idle data is inverted.
	task automatic put_char(input logic [7:0] c);
		int n;
		n = 0;
		@(posedge clk_in);
		cmd_data_out <= c;
		cmd_valid_out <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (cmd_ready_in !== 1'b1 && n < 200);
		cmd_valid_out <= 1'b0;
		cmd_data_out <= ~c;
	endtask
	// Collects answer bytes up to line feed; stall slows acceptance.
	task automatic get_line(input int maxn, output logic [95:0] l);
		int n;
		logic [7:0] b;
		n = 0;
		b = 8'h00;
		l = '0;
		while (b !== ASC_LF && n < maxn) begin
			@(posedge clk_in);
			n++;
			if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
				b = tx_data_in;
				l = {l[87:0], b};
			end
			tx_ready_out <= b !== ASC_LF && n < maxn && (stall == 0 || n % stall == 0);
		end
	endtask
endmodule

// >>> tb/test_rcp_parser.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module test_rcp_parser import rcp_pkg::*;;
	logic        clk_in, ce_in, sys_rst_in, cmd_valid_in, cmd_ready_out, bus_trigger_in, probe_switch_in;
	logic        meas_done_in, gate_active_in, probe_high_in, probe_low_in, talker_in, tx_valid_out, tx_ready_in;
	logic        recall_en_out, edit_en_out, sig_latch_en_out, unstable_latch_en_out, qualify_en_out;
	logic        clock_rising_out, start_rising_out, stop_rising_out, qual_high_out, free_run_out;
	logic        triggered_meas_out, send_pending_out;
	logic [15:0] sig_data_in, held_sig_out;
	logic [7:0]  cmd_data_in, tx_data_out;
	logic [1:0]  probe_state_in;
	logic [6:0]  error_code_in;
	logic [95:0] line;
	int          fail_count = 0, tests_run = 0, cyc = 0;
	string       s, fn = "RESUQ";
	localparam logic [15:0] NL = {ASC_CR, ASC_LF};
	localparam logic [15:0] RPT_TAB [4] = '{RPT_HIGH, RPT_LOW, RPT_PULSE, RPT_FLOAT};
	localparam logic [1:0]  SEEN_TAB [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
	wire [4:0] en = {recall_en_out, edit_en_out, sig_latch_en_out, unstable_latch_en_out, qualify_en_out};
	wire [3:0] pol = {clock_rising_out, start_rising_out, stop_rising_out, qual_high_out};

	rcp_parser u_dut (.clk_in, .ce_in, .sys_rst_in, .cmd_data_in, .cmd_valid_in, .cmd_ready_out,
		.bus_trigger_in, .probe_switch_in, .meas_done_in, .sig_data_in, .gate_active_in, .probe_high_in,
		.probe_low_in, .probe_state_in, .error_code_in, .talker_in, .tx_data_out, .tx_valid_out, .tx_ready_in,
		.recall_en_out, .edit_en_out, .sig_latch_en_out, .unstable_latch_en_out, .qualify_en_out,
		.clock_rising_out, .start_rising_out, .stop_rising_out, .qual_high_out, .free_run_out,
		.triggered_meas_out, .held_sig_out, .send_pending_out);
	rcp_bus_ctrl u_host (.clk_in, .cmd_ready_in(cmd_ready_out), .cmd_data_out(cmd_data_in),
		.cmd_valid_out(cmd_valid_in), .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out),
		.tx_ready_out(tx_ready_in));

	// The clock flips every half period of 20 ns.
	initial clk_in = 1'b0;
	always #20 clk_in = ~clk_in;
	// A cycle ceiling cuts a hang short.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("Checks run %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Sends a command string; par sets the parity bit of every character.
	task automatic cmd(input string t, input bit par = 1'b0);
		byte b;
		for (int i = 0; i < t.len(); i++) begin
			b = t[i];
			u_host.put_char({par, b[6:0]});
		end
		@(posedge clk_in);
	endtask
	task automatic ans(input logic [95:0] e, input int maxn = 400);
		u_host.get_line(maxn, line);
		`CHK(line, e)
	endtask
	// Pulses any of completion, bus trigger and probe switch, as mtp selects, for one cycle.
	task automatic pulse(input logic [2:0] mtp, input logic [15:0] v);
		@(posedge clk_in);
		{meas_done_in, bus_trigger_in, probe_switch_in} <= mtp;
		sig_data_in <= v;
		@(posedge clk_in);
		{meas_done_in, bus_trigger_in, probe_switch_in} <= 3'b000;
		@(posedge clk_in);
	endtask
	function automatic logic [7:0] hx(input logic [3:0] d);
		return (d < 4'hA) ? ASC_0 + 8'(d) : ASC_A + 8'(d) - 8'h0A;
	endfunction
	function automatic logic [47:0] sig_line(input logic [15:0] v);
		return {hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0]), NL};
	endfunction

	// Main sequence of scenarios.
	initial begin
		{ce_in, sys_rst_in, talker_in} = 3'b110;
		{gate_active_in, probe_high_in, probe_low_in, meas_done_in, bus_trigger_in, probe_switch_in} = 6'h00;
		sig_data_in = 16'h0000;
		probe_state_in = 2'h0;
		error_code_in = 7'h00;
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		`CHK({edit_en_out, sig_latch_en_out, unstable_latch_en_out}, 3'h0)
		`CHK({start_rising_out, stop_rising_out, free_run_out}, 3'h7)
		for (int i = 0; i < 5; i++) begin
			s = "fx1";
			s[1] = i[0] ? fn[i] + 8'h20 : fn[i];
			cmd(s, i[0]);
			`CHK(en, 5'h10 >> i)
			s[2] = "0";
			cmd(s);
			`CHK(en, 5'h00)
		end
		cmd("FS,fu1;FE;Fu5 FQ1");
		`CHK({en, free_run_out}, 6'h06)
		cmd("PC2PT2pp2PQ2FU0FQ0SP");
		`CHK(pol, 4'h0)
		ans({ASC_0, NL});
		cmd("pc1PT1PP1PQ1FQ1SP");
		`CHK(pol, 4'hF)
		ans({ASC_0 + 8'h05, ASC_0 + 8'h05, NL});
		cmd("FQ0se");
		ans({ASC_0, ASC_0, NL});
		error_code_in <= 7'h2A;
		u_host.stall = 3;
		cmd("SE");
		ans({ASC_0 + 8'h04, ASC_0 + 8'h02, NL});
		u_host.stall = 0;
		cmd("SI");
		ans({ID_TEXT, NL});
		for (int i = 0; i < 4; i++) begin
			probe_state_in <= 2'(i);
			cmd("SL1");
			ans({RPT_TAB[i], NL});
		end
		pulse(3'b100, 16'hA5C3);
		`CHK(held_sig_out, 16'hA5C3)
		pulse(3'b010, 16'h0000);
		`CHK(triggered_meas_out, 1'b1)
		pulse(3'b100, 16'h1234);
		`CHK({triggered_meas_out, held_sig_out}, 17'h01234)
		// With the enable low a completion and a trigger must leave no trace.
		ce_in <= 1'b0;
		pulse(3'b110, 16'h5A5A);
		`CHK({triggered_meas_out, held_sig_out}, 17'h01234)
		ce_in <= 1'b1;
		talker_in <= 1'b1;
		ans(sig_line(16'h1234));
		cmd("SS1");
		`CHK(send_pending_out, 1'b1)
		pulse(3'b100, 16'hBEEF);
		ans(96'h0, 30);
		pulse(3'b001, 16'h0000);
		`CHK(triggered_meas_out, 1'b1)
		pulse(3'b100, 16'h0F9C);
		ans(sig_line(16'h0F9C));
		pulse(3'b100, 16'h7E21);
		ans(sig_line(16'h7E21));
		cmd("SS1fr0");
		`CHK(send_pending_out, 1'b0)
		pulse(3'b100, 16'h3C5A);
		ans(sig_line(16'h3C5A));
		talker_in <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			cmd("SL2");
			`CHK(send_pending_out, 1'b1)
			pulse(3'b010, 16'h0000);
			{gate_active_in, probe_high_in, probe_low_in} <= {1'b1, SEEN_TAB[k]};
			repeat (4) @(posedge clk_in);
			{gate_active_in, probe_high_in, probe_low_in} <= 3'b000;
			ans({RPT_TAB[k], NL});
		end
		// A second reset in mid-run must bring the defaults back.
		cmd("FE1FS1pt2PP2");
		`CHK({edit_en_out, sig_latch_en_out, start_rising_out, stop_rising_out, free_run_out}, 5'h18)
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		`CHK({edit_en_out, sig_latch_en_out, start_rising_out, stop_rising_out, free_run_out}, 5'h07)
		conclude();
	end
endmodule
